// [ccr_pkg.sv]
// Package with register map, field positions and types for the chip configuration bank
package ccr_pkg;
  localparam logic [7:0] CCR_IDX_FIRST = 8'h20;
  localparam logic [7:0] CCR_IDX_LAST = 8'h2E;
  localparam logic [7:0] CCR_IDX_CHIP_ID = 8'h20;
  localparam logic [7:0] CCR_IDX_MAIN = 8'h21;
  localparam logic [7:0] CCR_IDX_PIN2 = 8'h22;
  localparam logic [7:0] CCR_IDX_PIN3 = 8'h23;
  localparam logic [7:0] CCR_IDX_PIN4 = 8'h24;
  localparam logic [7:0] CCR_IDX_PIN5 = 8'h25;
  localparam logic [7:0] CCR_IDX_REV_ID = 8'h27;
  localparam logic [7:0] CCR_IDX_CFG8 = 8'h28;
  localparam logic [7:0] CCR_IDX_SBA = 8'h2A;
  localparam logic [7:0] CCR_IDX_SBB = 8'h2B;
  localparam logic [7:0] CCR_IDX_SBC = 8'h2C;
  localparam logic [7:0] CCR_IDX_SBD = 8'h2D;
  // Main register fields
  localparam int CCR_LOCK_BIT = 7;
  localparam int CCR_PARALLEL_IRQ_INPUT_BIT = 6;
  localparam int CCR_DMA_LSB = 4;
  localparam int CCR_IO_LSB = 2;
  localparam int CCR_SWRST_BIT = 1;
  localparam int CCR_GEN_BIT = 0;
  // Reset values
  localparam logic [7:0] CCR_MAIN_RST = 8'h11;
  localparam logic [7:0] CCR_PIN2_RST = 8'h00;
  localparam logic [7:0] CCR_PIN3_RST = 8'h03;
  localparam logic [7:0] CCR_ZERO_RST = 8'h00;
  // Writable pin-select masks, lock protects these bits
  localparam logic [7:0] CCR_PIN4_RW_MASK = 8'hCF;
  localparam logic [7:0] CCR_MAIN_PIN_MASK = 8'h40;
  // Wait-state encodings
  localparam logic [1:0] CCR_WS_RSVD = 2'h0;
  localparam logic [3:0] CCR_WS_ZERO = 4'h0;
  localparam logic [3:0] CCR_WS_TWO = 4'h2;
  localparam logic [3:0] CCR_WS_SIX = 4'h6;
  localparam logic [3:0] CCR_WS_TWELVE = 4'hC;
  // AXI responses
  localparam logic [1:0] CCR_RESP_OKAY = 2'h0;

  typedef struct packed {
    logic [7:0] main;
    logic [7:0] pin2;
    logic [7:0] pin3;
    logic [7:0] pin4;
    logic [7:0] pin5;
    logic [7:0] cfg8;
    logic [7:0] sba;
    logic [7:0] sbb;
    logic [7:0] sbc;
    logic [7:0] sbd;
  } ccr_regs_t;

  typedef struct packed {
    logic [3:0] dma_wait;
    logic [3:0] io_wait;
    logic parallel_irq_input_sel;
    logic dev_enable;
    logic soft_reset;
    logic pin_lock;
  } ccr_ctrl_t;
endpackage : ccr_pkg

// [ccr_bank.sv]
// Chip configuration register bank with AXI4-Lite slave
// Behaviour
// - Registers decode at indexes 20h..2Eh; 2Eh is reserved.
// - Index 20h returns a fixed chip identity code; writes do nothing.
// - Lock bit 7 set makes the select bits of 22h..25h, 2Ah, 2Bh and bit 6 read-only; 2Ch and 2Dh stay writable.
// - Lock bit once set is cleared only by hardware reset.
// - Bit 6 selects parallel interrupt inputs for the upper pin group.
// - Bits 5-4 set DMA wait states: 01 two, 10 six, 11 twelve.
// - Bits 3-2 set I/O wait states: 00 zero, 01 two, 10 six, 11 twelve.
// - Software-reset bit reads 0; writing 0 is ignored.
// - Writing 1 resets devices and config registers; lock and wake-up unit registers SBA..SBD are kept.
// - Global enable 0 disables all devices except the wake-up unit.
`timescale 1ns/1ns
module ccr_bank #(
  parameter logic [7:0] CHIP_ID = 8'h5A,  // Arbitrary value
  parameter logic [7:0] REV_ID = 8'h01    // Arbitrary value
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control outputs to the chip
  output ccr_pkg::ccr_ctrl_t ctrl,
  output ccr_pkg::ccr_regs_t regs
);
  import ccr_pkg::*;

  typedef struct packed {
    ccr_regs_t r;
    ccr_ctrl_t c;
    logic aw_got;
    logic [7:0] aw_idx;
    logic w_got;
    logic [7:0] w_data;
    logic w_en;
    logic bvalid;
    logic rvalid;
    logic [7:0] rdata;
    logic awrdy;
    logic wrdy;
    logic ardy;
  } ccr_state_t;

  ccr_state_t st;
  ccr_state_t next_st;

  function automatic logic [3:0] ccr_dma_count(input logic [1:0] code);
    logic [3:0] n;
    n = CCR_WS_TWO;
    case (code)
      2'h2: n = CCR_WS_SIX;
      2'h3: n = CCR_WS_TWELVE;
      default: n = CCR_WS_TWO;
    endcase
    return n;
  endfunction : ccr_dma_count

  function automatic logic [3:0] ccr_io_count(input logic [1:0] code);
    logic [3:0] n;
    n = CCR_WS_ZERO;
    case (code)
      2'h1: n = CCR_WS_TWO;
      2'h2: n = CCR_WS_SIX;
      2'h3: n = CCR_WS_TWELVE;
      default: n = CCR_WS_ZERO;
    endcase
    return n;
  endfunction : ccr_io_count

  // Masked update: bits under lock keep their old value
  function automatic logic [7:0] ccr_upd(input logic [7:0] old, input logic [7:0] wr, input logic [7:0] lkm);
    return (old & lkm) | (wr & ~lkm);
  endfunction : ccr_upd

  function automatic logic [7:0] ccr_read(input ccr_regs_t r, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == CCR_IDX_CHIP_ID)
      v = CHIP_ID;
    else if (idx == CCR_IDX_MAIN)
      v = r.main & ~(8'h01 << CCR_SWRST_BIT);
    else if (idx == CCR_IDX_PIN2)
      v = r.pin2;
    else if (idx == CCR_IDX_PIN3)
      v = r.pin3;
    else if (idx == CCR_IDX_PIN4)
      v = r.pin4;
    else if (idx == CCR_IDX_PIN5)
      v = r.pin5;
    else if (idx == CCR_IDX_REV_ID)
      v = REV_ID;
    else if (idx == CCR_IDX_CFG8)
      v = r.cfg8;
    else if (idx == CCR_IDX_SBA)
      v = r.sba;
    else if (idx == CCR_IDX_SBB)
      v = r.sbb;
    else if (idx == CCR_IDX_SBC)
      v = r.sbc;
    else if (idx == CCR_IDX_SBD)
      v = r.sbd;
    else
      v = 8'h00;
    return v;
  endfunction : ccr_read

  logic lk;
  logic [7:0] lkm;
  logic [7:0] wd;
  logic wr_fire;
  logic [7:0] widx;

  always_comb
  begin
    next_st = st;
    lk = st.r.main[CCR_LOCK_BIT];
    lkm = lk ? 8'hFF : 8'h00;
    // No write-one-to-clear bits in this bank
    next_st.c.soft_reset = 1'b0;
    // Address and data channels taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_idx = {2'h0, s_axi_awaddr[7:2]};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata[7:0];
      next_st.w_en = s_axi_wstrb[0];
    end
    wr_fire = st.aw_got && st.w_got && !st.bvalid;
    widx = st.aw_idx;
    wd = st.w_data;
    if (wr_fire)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.w_en && widx >= CCR_IDX_FIRST && widx < CCR_IDX_LAST)
      begin
        if (widx == CCR_IDX_MAIN)
        begin
          // Lock is sticky high
          next_st.r.main[CCR_LOCK_BIT] = lk | wd[CCR_LOCK_BIT];
          next_st.r.main[CCR_PARALLEL_IRQ_INPUT_BIT] = lk ? st.r.main[CCR_PARALLEL_IRQ_INPUT_BIT] : wd[CCR_PARALLEL_IRQ_INPUT_BIT];
          if (wd[CCR_DMA_LSB +: 2] != CCR_WS_RSVD)
            next_st.r.main[CCR_DMA_LSB +: 2] = wd[CCR_DMA_LSB +: 2];
          next_st.r.main[CCR_IO_LSB +: 2] = wd[CCR_IO_LSB +: 2];
          next_st.r.main[CCR_SWRST_BIT] = 1'b0;
          next_st.r.main[CCR_GEN_BIT] = wd[CCR_GEN_BIT];
          next_st.c.soft_reset = wd[CCR_SWRST_BIT];
        end
        else if (widx == CCR_IDX_PIN2)
          next_st.r.pin2 = ccr_upd(st.r.pin2, wd, lkm);
        else if (widx == CCR_IDX_PIN3)
          next_st.r.pin3 = ccr_upd(st.r.pin3, wd, lkm);
        else if (widx == CCR_IDX_PIN4)
          next_st.r.pin4 = ccr_upd(st.r.pin4, wd, lkm | ~CCR_PIN4_RW_MASK);
        else if (widx == CCR_IDX_PIN5)
          next_st.r.pin5 = ccr_upd(st.r.pin5, wd, lkm);
        else if (widx == CCR_IDX_CFG8)
          next_st.r.cfg8 = wd;
        else if (widx == CCR_IDX_SBA)
          next_st.r.sba = ccr_upd(st.r.sba, wd, lkm);
        else if (widx == CCR_IDX_SBB)
          next_st.r.sbb = ccr_upd(st.r.sbb, wd, lkm);
        else if (widx == CCR_IDX_SBC)
          next_st.r.sbc = wd;
        else if (widx == CCR_IDX_SBD)
          next_st.r.sbd = wd;
      end
    end
    // Soft reset returns config to defaults, lock and standby well kept
    if (st.c.soft_reset)
    begin
      next_st.r.main = (CCR_MAIN_RST & ~(8'h01 << CCR_LOCK_BIT)) | (st.r.main & (8'h01 << CCR_LOCK_BIT));
      next_st.r.pin2 = CCR_PIN2_RST;
      next_st.r.pin3 = CCR_PIN3_RST;
      next_st.r.pin4 = CCR_ZERO_RST;
      next_st.r.pin5 = CCR_ZERO_RST;
      next_st.r.cfg8 = CCR_ZERO_RST;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // Read path
    if (s_axi_arvalid && st.ardy)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = ccr_read(st.r, {2'h0, s_axi_araddr[7:2]});
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    // Decoded controls
    next_st.c.pin_lock = next_st.r.main[CCR_LOCK_BIT];
    next_st.c.parallel_irq_input_sel = next_st.r.main[CCR_PARALLEL_IRQ_INPUT_BIT];
    next_st.c.dma_wait = ccr_dma_count(next_st.r.main[CCR_DMA_LSB +: 2]);
    next_st.c.io_wait = ccr_io_count(next_st.r.main[CCR_IO_LSB +: 2]);
    next_st.c.dev_enable = next_st.r.main[CCR_GEN_BIT];
    // Ready outputs registered from the next state
    next_st.awrdy = !next_st.aw_got && !next_st.bvalid;
    next_st.wrdy = !next_st.w_got && !next_st.bvalid;
    next_st.ardy = !next_st.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.r.main <= CCR_MAIN_RST;
      st.r.pin2 <= CCR_PIN2_RST;
      st.r.pin3 <= CCR_PIN3_RST;
      st.c.dma_wait <= CCR_WS_TWO;
      st.c.io_wait <= CCR_WS_ZERO;
      st.c.dev_enable <= 1'b1;
      st.awrdy <= 1'b1;
      st.wrdy <= 1'b1;
      st.ardy <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign s_axi_awready = st.awrdy;
  assign s_axi_wready = st.wrdy;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = CCR_RESP_OKAY;
  assign s_axi_arready = st.ardy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = {24'h000000, st.rdata};
  assign s_axi_rresp = CCR_RESP_OKAY;
  assign ctrl = st.c;
  assign regs = st.r;

  chk_lock_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    st.r.main[CCR_LOCK_BIT] |=> st.r.main[CCR_LOCK_BIT])
    else $error("lock bit cleared without reset");
  chk_locked_pin2: assert property (@(posedge aclk) disable iff (!aresetn)
    st.r.main[CCR_LOCK_BIT] && !st.c.soft_reset |=> $stable(st.r.pin2))
    else $error("locked pin select changed");
  chk_swrst_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.r.main[CCR_SWRST_BIT])
    else $error("soft reset bit stored");
  chk_dma_not_rsvd: assert property (@(posedge aclk) disable iff (!aresetn)
    st.r.main[CCR_DMA_LSB +: 2] != CCR_WS_RSVD && ctrl.dma_wait != CCR_WS_ZERO)
    else $error("dma wait reserved");
  chk_io_map: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.r.main[CCR_IO_LSB +: 2] == 2'h0) == (ctrl.io_wait == CCR_WS_ZERO))
    else $error("io wait map wrong");
  chk_gen_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.dev_enable == st.r.main[CCR_GEN_BIT])
    else $error("enable mismatch");
  chk_parallel_irq_input_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl.parallel_irq_input_sel == st.r.main[CCR_PARALLEL_IRQ_INPUT_BIT])
    else $error("parallel_irq_input select mismatch");
  chk_swrst_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
    st.c.soft_reset |=> st.r.pin2 == CCR_PIN2_RST && st.r.pin3 == CCR_PIN3_RST && st.r.main[CCR_GEN_BIT])
    else $error("soft reset did not restore");
  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read answer late");

  // Step sequences for reads, writes and soft reset
  sequence s_rd_taken(logic [7:0] idx);
    s_axi_arvalid && s_axi_arready && {2'h0, s_axi_araddr[7:2]} == idx;
  endsequence
  sequence s_wr_unmapped;
    wr_fire && (st.aw_idx < CCR_IDX_FIRST || st.aw_idx >= CCR_IDX_LAST);
  endsequence
  sequence s_swrst_pulse;
    st.c.soft_reset;
  endsequence
  sequence s_swrst_restored;
    st.r.pin4 == CCR_ZERO_RST && st.r.pin5 == CCR_ZERO_RST && st.r.cfg8 == CCR_ZERO_RST && !st.c.soft_reset;
  endsequence

  chk_id_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_taken(CCR_IDX_CHIP_ID) |=> s_axi_rdata[7:0] == CHIP_ID)
    else $error("chip identity read wrong");
  chk_rev_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_taken(CCR_IDX_REV_ID) |=> s_axi_rdata[7:0] == REV_ID)
    else $error("revision identity read wrong");
  chk_rsvd_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_taken(CCR_IDX_LAST) |=> s_axi_rdata == 32'h00000000)
    else $error("reserved index read not zero");
  chk_main_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_taken(CCR_IDX_MAIN) |=> !s_axi_rdata[CCR_SWRST_BIT])
    else $error("soft reset bit read as one");

  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write answer missing");
  chk_ready_reg: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awready == (!st.aw_got && !st.bvalid))
    else $error("address ready wrong");

  chk_unmapped_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_unmapped |=> $stable(st.r))
    else $error("unmapped write changed state");
  chk_id_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && st.aw_idx == CCR_IDX_CHIP_ID |=> $stable(st.r))
    else $error("identity write changed state");

  chk_swrst_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_swrst_pulse |=> s_swrst_restored)
    else $error("soft reset not restored");
  chk_swrst_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    st.c.soft_reset |=> st.r.main[CCR_LOCK_BIT] == $past(st.r.main[CCR_LOCK_BIT]))
    else $error("soft reset changed lock");
  chk_locked_rest: assert property (@(posedge aclk) disable iff (!aresetn)
    st.r.main[CCR_LOCK_BIT] && !st.c.soft_reset |=> $stable(st.r.pin3) && $stable(st.r.pin5)
      && $stable(st.r.sba) && $stable(st.r.sbb) && $stable(st.r.main[CCR_PARALLEL_IRQ_INPUT_BIT]))
    else $error("locked select changed");
  chk_pin4_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.r.pin4 & ~CCR_PIN4_RW_MASK) == CCR_ZERO_RST)
    else $error("pin group bits written");
endmodule : ccr_bank

// [ccr_bank_tb.sv]
// Self-checking testbench for the chip configuration register bank
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module ccr_bank_tb;
  import ccr_pkg::*;
  localparam logic [7:0] CID = 8'hA7;  // Arbitrary value
  localparam logic [7:0] RID = 8'h3C;  // Arbitrary value
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  ccr_ctrl_t ctrl;
  ccr_regs_t regs;
  int num_errors = 0;
  int n_tests = 0;
  logic sr_seen;
  logic [7:0] m [0:63];
  logic [3:0] wst [0:3] = '{4'h0, 4'h2, 4'h6, 4'hC};

  always #2 aclk = ~aclk;

  ccr_bank #(.CHIP_ID(CID), .REV_ID(RID)) ccr_bank_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ctrl(ctrl), .regs(regs)
  );

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic fail_to();
    num_errors++;
    $display("ERROR %0t: handshake timeout", $time);
    end_of_test();
  endtask : fail_to

  // Model: soft reset keeps the lock and the standby registers
  task automatic mdl_rst(input bit hard);
    logic lk;
    lk = m[8'h21][7] & ~hard;
    if (hard) foreach (m[i]) m[i] = 8'h00;
    m[8'h21] = {lk, 7'h11};
    m[8'h22] = 8'h00;
    m[8'h23] = 8'h03;
    m[8'h24] = 8'h00;
    m[8'h25] = 8'h00;
    m[8'h28] = 8'h00;
  endtask : mdl_rst

  task automatic mdl_wr(input logic [7:0] idx, input logic [7:0] d);
    logic lk;
    lk = m[8'h21][7];
    case (idx)
      8'h21: if (d[1]) mdl_rst(1'b0);
        else m[idx] = {lk | d[7], lk ? m[idx][6] : d[6], (d[5:4] == 2'b00) ? m[idx][5:4] : d[5:4], d[3:2], 1'b0, d[0]};
      8'h22, 8'h23, 8'h25, 8'h2A, 8'h2B: if (!lk) m[idx] = d;
      8'h24: if (!lk) m[idx] = d & CCR_PIN4_RW_MASK;
      8'h28, 8'h2C, 8'h2D: m[idx] = d;
      default: ;
    endcase
  endtask : mdl_wr

  function automatic logic [7:0] mdl_rd(input logic [7:0] idx);
    if (idx == CCR_IDX_CHIP_ID) return CID;
    if (idx == CCR_IDX_REV_ID) return RID;
    return m[idx[5:0]];
  endfunction : mdl_rd

  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
    int k;
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    resp = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      if (b_hs) sr_seen = ctrl.soft_reset;
      if (b_hs) resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) break;
    end
    if (k == 40) fail_to();
    `CHK(resp, CCR_RESP_OKAY)
    s_axi_bready <= 1'b0;
    mdl_wr(idx, d);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx);
    int k;
    logic ar_hs, r_hs;
    logic [31:0] rd;
    logic [1:0] resp;
    rd = 32'hFFFFFFFF;
    resp = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      if (r_hs) rd = s_axi_rdata;
      if (r_hs) resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) break;
    end
    if (k == 40) fail_to();
    `CHK(rd, {24'h000000, mdl_rd(idx)})
    `CHK(resp, CCR_RESP_OKAY)
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic chk_ctrl();
    logic [7:0] mm;
    repeat (2) @(posedge aclk);
    mm = m[8'h21];
    `CHK(ctrl.dma_wait, wst[mm[5:4]])
    `CHK(ctrl.io_wait, wst[mm[3:2]])
    `CHK({ctrl.pin_lock, ctrl.parallel_irq_input_sel, ctrl.dev_enable, ctrl.soft_reset}, {mm[7], mm[6], mm[0], 1'b0})
    `CHK({regs.pin2, regs.pin4, regs.cfg8, regs.sbd}, {m[8'h22], m[8'h24], m[8'h28], m[8'h2D]})
  endtask : chk_ctrl

  task automatic chk_all();
    for (int i = 8'h1F; i <= 8'h2F; i++) axi_rd(8'(i));
    chk_ctrl();
  endtask : chk_all

  task automatic rnd_all();
    for (int i = 8'h20; i <= 8'h2F; i++) if (i != 8'h21) axi_wr(8'(i), 8'($urandom));
  endtask : rnd_all

  task automatic hw_rst();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    mdl_rst(1'b1);
  endtask : hw_rst

  initial
  begin
    void'($urandom(20));
    hw_rst();
    chk_all();
    $display("Test reset values done");
    rnd_all();
    chk_all();
    $display("Test random writes done");
    for (int i = 0; i < 16; i++)
    begin
      axi_wr(CCR_IDX_MAIN, {1'b0, i[0], i[3:0], 1'b0, ~i[0]});
      `CHK(sr_seen, 1'b0)
      chk_ctrl();
    end
    axi_rd(CCR_IDX_MAIN);
    $display("Test wait states done");
    axi_wr(CCR_IDX_MAIN, 8'h4E);
    `CHK(sr_seen, 1'b1)
    chk_all();
    $display("Test soft reset done");
    rnd_all();
    axi_wr(CCR_IDX_MAIN, 8'hF5);
    rnd_all();
    axi_wr(CCR_IDX_MAIN, 8'h01);
    chk_all();
    axi_wr(CCR_IDX_MAIN, 8'h02);
    `CHK(sr_seen, 1'b1)
    chk_all();
    $display("Test lock done");
    hw_rst();
    chk_all();
    $display("Test hardware reset done");
    end_of_test();
  end
endmodule : ccr_bank_tb
